// File: hdl/swo_pkg.sv
package swo_pkg;

  // Clock rate
  localparam int unsigned CLK_HZ = 25_000_000;

  // Timing figures in their own units
  localparam int unsigned OC_PULSE_MS = 50;
  localparam int unsigned HOLD_TIME_S = 600;
  localparam int unsigned STANDBY_INDICATOR_RELEASE_MS = 100;
  localparam int unsigned ON_RELEASE_MS = 100;
  localparam int unsigned FILTER_US = 20;

  // Least times round up to whole cycles
  localparam longint unsigned OC_PULSE_CYC = (64'(OC_PULSE_MS) * CLK_HZ + 999) / 1000;
  localparam longint unsigned HOLD_CYC = 64'(HOLD_TIME_S) * CLK_HZ;
  localparam longint unsigned STANDBY_INDICATOR_REL_CYC = (64'(STANDBY_INDICATOR_RELEASE_MS) * CLK_HZ + 999) / 1000;
  localparam longint unsigned ON_REL_CYC = (64'(ON_RELEASE_MS) * CLK_HZ + 999) / 1000;
  localparam longint unsigned FILTER_CYC = (64'(FILTER_US) * CLK_HZ + 999_999) / 1_000_000;

  // Counter width shared by all timers
  localparam int unsigned CNT_W = 40;

  // Reset value of the active-low overcurrent flags and active indicator (released)
  localparam logic IND_RESET = 1'b1;

  // Power state machine
  typedef enum logic [3:0] {
    SWO_STANDBY  = 4'b0001,
    SWO_STARTING = 4'b0010,
    SWO_ON       = 4'b0100,
    SWO_STOPPING = 4'b1000
  } swo_state_e;

  // Wake-request inputs grouped together
  typedef struct packed {
    logic standby;
    logic remote_wake;
    logic presence_pos;
    logic presence_neg;
  } swo_wake_s;

  // Active-low indicator group
  typedef struct packed {
    logic standby_indicator_n;
    logic active_indicator_n;
  } swo_ind_s;

endpackage

// File: hdl/swo_stretch.sv
`timescale 1ns/1ps
// Retriggerable pulse stretcher, active-low output from a flip-flop
module swo_stretch #(
  parameter longint unsigned LEN = 2
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Event in, stretched flag out
  input wire logic event_i,
  output logic flag_n_o
);

  logic [swo_pkg::CNT_W-1:0] cnt_q;
  logic [swo_pkg::CNT_W-1:0] cnt_d;
  wire busy = (cnt_q != '0);

  // Reload value must be non-zero and fit the shared counter width
  if (LEN < 1 || LEN > (64'd1 << swo_pkg::CNT_W) - 64'd1) begin : g_bad_len
    $error("LEN must be at least one cycle and fit the counter");
  end

  // New event reloads the full interval
  assign cnt_d = event_i ? swo_pkg::CNT_W'(LEN) : (busy ? cnt_q - 1'b1 : cnt_q);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= '0;
      flag_n_o <= swo_pkg::IND_RESET;
    end else begin
      cnt_q <= cnt_d;
      // Low while any count is left; an event reloads LEN, so it is low too
      flag_n_o <= (cnt_d == '0);
    end
  end

endmodule // swo_stretch

// File: hdl/swo_top.sv
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module swo_top #(
  parameter int unsigned NUM_CH = 2,
  parameter longint unsigned OC_PULSE_CYC = swo_pkg::OC_PULSE_CYC,
  parameter longint unsigned HOLD_CYC = swo_pkg::HOLD_CYC,
  parameter longint unsigned STANDBY_INDICATOR_REL_CYC = swo_pkg::STANDBY_INDICATOR_REL_CYC,
  parameter longint unsigned ON_REL_CYC = swo_pkg::ON_REL_CYC,
  parameter longint unsigned FILTER_CYC = swo_pkg::FILTER_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Wake controls (standby high means standby requested)
  input wire swo_pkg::swo_wake_s wake_i,
  // Cycle-by-cycle current limit pulses per channel
  input wire logic [1:0] oc_event_i,
  // Active-low status indicators
  output logic overcurrent_flag_ch1_o,
  output logic overcurrent_flag_ch2_o,
  output swo_pkg::swo_ind_s ind_o,
  // Hold timer running
  output logic hold_active_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  // Every timer shares one counter width, so each count must fit in it
  localparam longint unsigned CNT_MAX = (64'd1 << swo_pkg::CNT_W) - 64'd1;

  if (NUM_CH < 1 || NUM_CH > 2) begin : g_bad_num_ch
    $error("NUM_CH must be 1 or 2");
  end
  if (OC_PULSE_CYC < 1 || HOLD_CYC < 1 || FILTER_CYC < 1) begin : g_bad_short
    $error("Pulse, hold and filter counts must be at least one cycle");
  end
  if (STANDBY_INDICATOR_REL_CYC < 1 || ON_REL_CYC < 1) begin : g_bad_delay
    $error("Indicator delays must be at least one cycle");
  end
  if (OC_PULSE_CYC > CNT_MAX || HOLD_CYC > CNT_MAX || FILTER_CYC > CNT_MAX) begin : g_bad_wide
    $error("Pulse, hold or filter count exceeds the timer width");
  end
  if (STANDBY_INDICATOR_REL_CYC > CNT_MAX || ON_REL_CYC > CNT_MAX) begin : g_bad_wide_dly
    $error("Indicator delay exceeds the timer width");
  end

  // Limitation: pins are taken as synchronous levels; anything asynchronous
  // needs a synchroniser in front of this block.
  // Detections while awake by standby low or remote wake do not start the hold timer.

  //////////////////////////////////////////////////////////////////////////////
  // Overcurrent flags

  logic [1:0] oc_flag_n;
  // Single-channel build: channel two events never reach its stretcher
  wire ch2_present = (NUM_CH == 2);
  wire [1:0] oc_gated = {oc_event_i[1] && ch2_present, oc_event_i[0]};

  // Both stretchers always built so the unused flag is still a register output
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_oc
      swo_stretch #(
        .LEN(OC_PULSE_CYC)
      ) u_stretch (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .event_i(oc_gated[g]),
        .flag_n_o(oc_flag_n[g])
      );
    end
  endgenerate

  assign overcurrent_flag_ch1_o = oc_flag_n[0];
  assign overcurrent_flag_ch2_o = oc_flag_n[1];

  //////////////////////////////////////////////////////////////////////////////
  // Presence filter: differential level must persist before it counts

  // Pair counts as present only while pos is high and neg is low
  wire presence_raw = wake_i.presence_pos && !wake_i.presence_neg;
  logic [swo_pkg::CNT_W-1:0] filt_q;
  logic detect_q;
  // Counter saturates at the filter length; any low sample starts it over
  wire filt_full = (filt_q >= swo_pkg::CNT_W'(FILTER_CYC));
  wire [swo_pkg::CNT_W-1:0] filt_inc = filt_full ? filt_q : filt_q + 1'b1;
  wire [swo_pkg::CNT_W-1:0] filt_d = presence_raw ? filt_inc : '0;
  // Registered detect costs a cycle but keeps the hold load glitch-free
  wire detect_d = presence_raw && filt_full;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      filt_q <= '0;
      detect_q <= 1'b0;
    end else begin
      filt_q <= filt_d;
      detect_q <= detect_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Presence hold timer

  logic [swo_pkg::CNT_W-1:0] hold_q;
  wire hold_run = (hold_q != '0);
  // Presence only acts while standby requested and remote wake low
  wire sense_en = wake_i.standby && !wake_i.remote_wake;
  // Every qualified detection reloads the full hold time
  wire hold_load = detect_q && sense_en;
  wire [swo_pkg::CNT_W-1:0] hold_dec = hold_run ? hold_q - 1'b1 : hold_q;
  wire [swo_pkg::CNT_W-1:0] hold_d = hold_load ? swo_pkg::CNT_W'(HOLD_CYC) : hold_dec;

  // Standby high is the standby request; wake or hold timer overrides it
  wire standby_indicator_req = wake_i.standby;
  wire remote_req = wake_i.standby && wake_i.remote_wake;
  // A running hold timer masks the standby request
  wire want_on = !standby_indicator_req || remote_req || hold_run;

  //////////////////////////////////////////////////////////////////////////////
  // Power state machine and indicator delays

  swo_pkg::swo_state_e state_q;
  swo_pkg::swo_state_e state_d;
  logic [swo_pkg::CNT_W-1:0] dly_q;
  logic [swo_pkg::CNT_W-1:0] dly_d;
  wire dly_done = (dly_q == swo_pkg::CNT_W'(1));
  // Delay counter runs down to zero and rests there
  wire [swo_pkg::CNT_W-1:0] dly_dec = (dly_q != '0) ? dly_q - 1'b1 : dly_q;

  always_comb begin
    state_d = state_q;
    dly_d = dly_dec;
    unique case (state_q)
      swo_pkg::SWO_STANDBY: begin
        // Any wake source starts the standby release delay
        if (want_on) begin
          state_d = swo_pkg::SWO_STARTING;
          dly_d = swo_pkg::CNT_W'(STANDBY_INDICATOR_REL_CYC);
        end
      end
      swo_pkg::SWO_STARTING: begin
        // Standby during start-up aborts straight to power-down
        if (!want_on) begin
          state_d = swo_pkg::SWO_STOPPING;
          dly_d = swo_pkg::CNT_W'(ON_REL_CYC);
        end else if (dly_done) begin
          state_d = swo_pkg::SWO_ON;
        end
      end
      swo_pkg::SWO_ON: begin
        // Active indicator lingers for the release delay
        if (!want_on) begin
          state_d = swo_pkg::SWO_STOPPING;
          dly_d = swo_pkg::CNT_W'(ON_REL_CYC);
        end
      end
      swo_pkg::SWO_STOPPING: begin
        // Re-wake during power-down restarts the start-up sequence
        if (want_on) begin
          state_d = swo_pkg::SWO_STARTING;
          dly_d = swo_pkg::CNT_W'(STANDBY_INDICATOR_REL_CYC);
        end else if (dly_done) begin
          state_d = swo_pkg::SWO_STANDBY;
        end
      end
      default: begin
        state_d = swo_pkg::SWO_STANDBY;
        dly_d = '0;
      end
    endcase
  end

  // Indicators follow the next state so outputs change with the transition
  wire next_standby = (state_d == swo_pkg::SWO_STANDBY);
  wire next_on = (state_d == swo_pkg::SWO_ON);
  wire next_stopping = (state_d == swo_pkg::SWO_STOPPING);
  // Aborted start-up keeps standby low: released only after the full delay
  wire standby_indicator_kept = next_stopping && ind_o.standby_indicator_n;
  wire standby_indicator_n_d = next_on || standby_indicator_kept;
  wire on_n_d = next_standby;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      hold_q <= '0;
      hold_active_o <= 1'b0;
    end else begin
      hold_q <= hold_d;
      hold_active_o <= (hold_d != '0);
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= swo_pkg::SWO_STANDBY;
      dly_q <= '0;
    end else begin
      state_q <= state_d;
      dly_q <= dly_d;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ind_o.standby_indicator_n <= 1'b0;
      ind_o.active_indicator_n <= swo_pkg::IND_RESET;
    end else begin
      ind_o.standby_indicator_n <= standby_indicator_n_d;
      ind_o.active_indicator_n <= on_n_d;
    end
  end

endmodule // swo_top

// File: verification/swo_props.sv
`timescale 1ns/1ps
module swo_props #(
  parameter int NUM_CH = 2,
  parameter int OC_PULSE_CYC = 4,
  parameter int STANDBY_INDICATOR_REL_CYC = 3,
  parameter int ON_REL_CYC = 3
) (
  // Watched ports
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire swo_pkg::swo_wake_s wake_i,
  input wire logic [1:0] oc_event_i,
  input wire logic overcurrent_flag_ch1_o,
  input wire logic overcurrent_flag_ch2_o,
  input wire swo_pkg::swo_ind_s ind_o,
  input wire logic hold_active_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic [7:0] oc_q;
  logic [7:0] st_q;
  wire logic act_n = ind_o.active_indicator_n;
  wire logic sby_n = ind_o.standby_indicator_n;
  // Power-down starts on a cycle that is active but has no wake reason left
  wire logic want_w = !wake_i.standby || wake_i.remote_wake || hold_active_o;
  wire logic stop_w = !act_n && !want_w;
  // Age of last ch1 event; OC_PULSE_CYC + 1 on the first cycle after the stretch, zero after that
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) oc_q <= 8'h00;
    else oc_q <= oc_event_i[0] ? 8'h01 : (oc_q == 8'(OC_PULSE_CYC + 1) || oc_q == 8'h00) ? 8'h00 : oc_q + 8'h01;
  end
  // Cycles with both indicators low, saturating
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) st_q <= 8'h00;
    else st_q <= (act_n || sby_n) ? 8'h00 : (&st_q) ? st_q : st_q + 8'h01;
  end
  oc_flag1_a: assert property (oc_event_i[0] |=> !overcurrent_flag_ch1_o)
    else $error("ch1 flag not low after event");
  oc_flag2_a: assert property (NUM_CH == 2 && oc_event_i[1] |=> !overcurrent_flag_ch2_o)
    else $error("ch2 flag not low after event");
  single_ch_a: assert property (NUM_CH == 1 |-> overcurrent_flag_ch2_o)
    else $error("ch2 flag asserted in single build");
  oc_hold_a: assert property (oc_q != 8'h00 && oc_q <= 8'(OC_PULSE_CYC) |-> !overcurrent_flag_ch1_o)
    else $error("ch1 flag released early");
  oc_end_a: assert property (oc_q == 8'(OC_PULSE_CYC + 1) |-> overcurrent_flag_ch1_o)
    else $error("ch1 flag held too long");
  wake_on_a: assert property (act_n && (!wake_i.standby || wake_i.remote_wake) |=> !act_n)
    else $error("active indicator late on wake");
  hold_on_a: assert property (hold_active_o && !act_n |=> !act_n)
    else $error("left operation while hold runs");
  standby_indicator_low_a: assert property (act_n |-> !sby_n)
    else $error("standby indicator high in standby");
  standby_indicator_rel_a: assert property ($rose(sby_n) |-> st_q >= 8'(STANDBY_INDICATOR_REL_CYC))
    else $error("standby indicator released early");
  on_rel_a: assert property ($rose(act_n) |-> $past(stop_w, ON_REL_CYC + 1))
    else $error("active indicator release delay wrong");
  cov_oc_c: cover property (oc_event_i[0] ##1 !overcurrent_flag_ch1_o);
  cov_wake_c: cover property ($fell(act_n));
  cov_hold_c: cover property ($rose(hold_active_o));
endmodule // swo_props
bind swo_top swo_props #(.NUM_CH(NUM_CH), .OC_PULSE_CYC(OC_PULSE_CYC), .STANDBY_INDICATOR_REL_CYC(STANDBY_INDICATOR_REL_CYC),
  .ON_REL_CYC(ON_REL_CYC)) u_props (.clk_i, .resetn_i, .wake_i, .oc_event_i, .overcurrent_flag_ch1_o,
  .overcurrent_flag_ch2_o, .ind_o, .hold_active_o);

// File: verification/swo_front.sv
`timescale 1ns/1ps
// Front-end board; callers enter its tasks on falling edges only
module swo_front (
  // Clock
  input wire logic clk_i,
  // Pins toward the amplifier
  output swo_pkg::swo_wake_s wake_o,
  output logic [1:0] oc_o
);
  // Quiet pair idles with neg high so no presence is seen
  initial begin
    wake_o = swo_pkg::swo_wake_s'(4'h9);
    oc_o = 2'h0;
  end
  task set_wake(input logic s, input logic r);
    wake_o.standby = s;
    wake_o.remote_wake = r;
  endtask
  task burst(input int n);
    wake_o.presence_pos = 1'b1;
    wake_o.presence_neg = 1'b0;
    repeat (n) @(negedge clk_i);
    wake_o.presence_pos = 1'b0;
    wake_o.presence_neg = 1'b1;
  endtask
  task pulse(input logic [1:0] ch);
    oc_o = ch;
    @(negedge clk_i);
    oc_o = 2'h0;
  endtask
endmodule // swo_front

// File: verification/swo_top_bench.sv
`timescale 1ns/1ps
module swo_top_bench;
  localparam int OC = 4;
  localparam int HOLD = 20;
  localparam int SREL = 3;
  localparam int OREL = 3;
  localparam int FILT = 2;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  int errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  swo_pkg::swo_wake_s wake;
  swo_pkg::swo_ind_s ind;
  logic [1:0] oc;
  logic f1_n, f2_n, f2s_n, hold;
  wire logic [3:0] mon = {hold, ind.active_indicator_n, ind.standby_indicator_n, f1_n};
  always #20 clk_i = ~clk_i;
  swo_front u_fe (.clk_i, .wake_o(wake), .oc_o(oc));
  swo_top #(.OC_PULSE_CYC(OC), .HOLD_CYC(HOLD), .STANDBY_INDICATOR_REL_CYC(SREL), .ON_REL_CYC(OREL),
    .FILTER_CYC(FILT)) u_dut (.clk_i, .resetn_i, .wake_i(wake), .oc_event_i(oc),
    .overcurrent_flag_ch1_o(f1_n), .overcurrent_flag_ch2_o(f2_n), .ind_o(ind), .hold_active_o(hold));
  swo_top #(.NUM_CH(1), .OC_PULSE_CYC(OC), .HOLD_CYC(HOLD), .STANDBY_INDICATOR_REL_CYC(SREL),
    .ON_REL_CYC(OREL)) u_dut_single (.clk_i, .resetn_i, .wake_i(wake), .oc_event_i(oc),
    .overcurrent_flag_ch1_o(), .overcurrent_flag_ch2_o(f2s_n), .ind_o(), .hold_active_o());
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Cycles a monitored output keeps one level, bounded
  task meas(input int i, input logic v);
    n = 0;
    while (mon[i] === v && n < 100) begin
      n++;
      @(negedge clk_i);
    end
  endtask
  task stop_test;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    repeat (8) @(negedge clk_i);
    resetn_i = 1'b1;
    chk({ind, f1_n, f2_n, f2s_n}, 5'h0f);
    u_fe.pulse(2'h1);
    meas(0, 1'b0);
    chk(n, OC);
    u_fe.pulse(2'h3);
    repeat (2) @(negedge clk_i);
    chk({f2_n, f2s_n}, 2'h1);
    meas(0, 1'b0);
    u_fe.pulse(2'h1);
    @(negedge clk_i);
    u_fe.pulse(2'h1);
    meas(0, 1'b0);
    chk(n, OC);
    u_fe.set_wake(1'b1, 1'b1);
    @(negedge clk_i);
    chk(ind.active_indicator_n, 1'b0);
    meas(1, 1'b0);
    chk(n, SREL);
    u_fe.set_wake(1'b1, 1'b0);
    meas(2, 1'b0);
    chk(n, OREL + 1);
    chk(ind, 2'h1);
    u_fe.burst(FILT);
    repeat (8) @(negedge clk_i);
    chk(hold, 1'b0);
    u_fe.burst(FILT + 1);
    meas(3, 1'b0);
    meas(3, 1'b1);
    chk(n, HOLD);
    repeat (10) @(negedge clk_i);
    u_fe.burst(FILT + 1);
    meas(3, 1'b0);
    repeat (15) @(negedge clk_i);
    u_fe.burst(FILT + 1);
    repeat (8) @(negedge clk_i);
    chk({hold, ind.active_indicator_n}, 2'h2);
    meas(3, 1'b1);
    repeat (8) @(negedge clk_i);
    chk(ind, 2'h1);
    u_fe.set_wake(1'b0, 1'b0);
    @(negedge clk_i);
    chk(ind.active_indicator_n, 1'b0);
    stop_test();
  end
endmodule // swo_top_bench
